// ===== design/banked_mem_defs.vh
`ifndef BANKED_MEM_DEFS_VH
`define BANKED_MEM_DEFS_VH

// ----------------------------------------------------------------------
// Bus register byte offsets
// ----------------------------------------------------------------------
`define REG_ACCESS      8'h00
`define REG_INSTR       8'h04
`define REG_PC          8'h08
`define REG_RETURN      8'h0c
`define REG_STATUS      8'h10
`define REG_LAST_READ   8'h14

// ----------------------------------------------------------------------
// Access command fields
// ----------------------------------------------------------------------
`define ACC_ADDR_MSB    11
`define ACC_BANKED_BIT  12
`define ACC_USEBANK_BIT 13
`define ACC_WRITE_BIT   14
`define ACC_DATA_LSB    16
`define ACC_DATA_MSB    23

// ----------------------------------------------------------------------
// Memory map
// ----------------------------------------------------------------------
`define GPR_LIMIT       12'hf60
`define SFR_BASE        12'hf60
`define ACCESS_SPLIT    8'h60
`define BANK_LOW        4'h0
`define BANK_HIGH       4'hf
`define SFR_PC_UPPER_LATCH 12'hffb
`define SFR_PC_HIGH_LATCH  12'hffa
`define SFR_PC_LOW      12'hff9
`define SFR_TBL_UPPER   12'hff8
`define SFR_TBL_HIGH    12'hff7
`define SFR_TBL_LOW     12'hff6
`define SFR_TABLE_LATCH 12'hff5
`define SFR_WORKING     12'hfe8
`define SFR_BANK_SEL    12'hfe0
`define SFR_PTR_LO_BASE 12'hfe9
`define SFR_PTR_STRIDE  12'h008
`define SFR_PTR_HI_OFS  12'h001
`define SFR_IND_OP_OFS  12'h006

// ----------------------------------------------------------------------
// Instruction word decode
// ----------------------------------------------------------------------
`define OPC_XFER_FIRST  4'hc
`define OPC_SECOND_WORD 4'hf
`define OPC_ADD_W       6'h09
`define OPC_TEST_ZERO   7'h33
`define OPC_MOVE_FILE   6'h14
`define OPC_RET_LIT     8'h0c
`define PC_STEP         21'h000002
`define PC_RESET        21'h000000

`endif

// ===== design/data_ram.v
// ----------------------------------------------------------------------
// General purpose storage, registered read, no reset on contents
// ----------------------------------------------------------------------
module data_ram #(
  parameter AW = 12,
  parameter DW = 8
) (
  input  wire          ref_clk,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Contents survive every reset source
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // data_ram

// ===== design/addr_former.v
`include "banked_mem_defs.vh"

// ----------------------------------------------------------------------
// Effective data address: banking, access region, indirect remap
// ----------------------------------------------------------------------
module addr_former (
  input  wire [11:0] raw_addr,
  input  wire        banked,
  input  wire        use_bank,
  input  wire [3:0]  bank_sel,
  input  wire [35:0] ptr_bus,
  output reg  [11:0] eff_addr
);

  reg [11:0] direct;
  integer    i;

  // Indirect operand replaces the address by its full 12-bit pointer
  always @* begin
    direct = raw_addr;
    if (banked) begin
      if (use_bank) begin
        direct = {bank_sel, raw_addr[7:0]};
      end else if (raw_addr[7:0] < `ACCESS_SPLIT) begin
        direct = {`BANK_LOW, raw_addr[7:0]};
      end else begin
        direct = {`BANK_HIGH, raw_addr[7:0]};
      end
    end
    eff_addr = direct;
    for (i = 0; i < 3; i = i + 1) begin
      if (direct == `SFR_PTR_LO_BASE - i[11:0] * `SFR_PTR_STRIDE + `SFR_IND_OP_OFS) begin
        eff_addr = ptr_bus[i*12 +: 12];
      end
    end
  end

endmodule // addr_former

// ===== design/banked_data_memory_addressing.v
// The register offsets and the Wishbone register port are this design's own decisions.
`include "banked_mem_defs.vh"

module banked_data_memory_addressing #(
  parameter GPR_TOP = `GPR_LIMIT
) (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg  [20:0] program_counter
);

  // --------------------------------------------------------------------
  // States and operations
  // --------------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_READ = 2'd1;
  localparam ST_EXEC = 2'd2;

  localparam OP_BUS_RD = 3'd0;
  localparam OP_BUS_WR = 3'd1;
  localparam OP_ADD    = 3'd2;
  localparam OP_TEST   = 3'd3;
  localparam OP_MOVE   = 3'd4;
  localparam OP_XFER   = 3'd5;

  // --------------------------------------------------------------------
  // Core state
  // --------------------------------------------------------------------
  reg  [1:0]  state_reg;
  reg  [2:0]  op_reg;
  reg         to_file_reg;
  reg  [7:0]  bus_data_reg;
  reg  [7:0]  working_register;
  reg  [3:0]  bank_select_reg;
  reg  [7:0]  pc_high_latch;
  reg  [4:0]  pc_upper_latch;
  reg  [21:0] table_pointer;
  reg  [7:0]  table_latch;
  reg  [20:0] return_addr_reg;
  reg  [7:0]  last_read_reg;
  reg         skip_pending_reg;
  reg         xfer_pending_reg;
  reg  [11:0] xfer_src_reg;
  reg  [11:0] rd_addr_reg;
  reg  [11:0] wr_addr_reg;
  reg  [7:0]  sfr_q_reg;
  reg         rd_gpr_reg;
  wire [35:0] ptr_bus;
  wire [7:0]  ram_q;

  // --------------------------------------------------------------------
  // Bus request decode
  // --------------------------------------------------------------------
  wire        take      = wb_cyc_i & wb_stb_i & ~wb_ack_o & (state_reg == ST_IDLE);
  wire        take_wr   = take & wb_we_i & wb_sel_i[0];
  wire [7:0]  reg_ofs   = {wb_adr_i[7:2], 2'b00};
  wire [15:0] instr     = wb_dat_i[15:0];
  wire        is_instr  = take_wr & (reg_ofs == `REG_INSTR);
  wire        is_access = take_wr & (reg_ofs == `REG_ACCESS);

  // Instruction classes
  wire dec_xfer1 = (instr[15:12] == `OPC_XFER_FIRST);
  wire dec_word2 = (instr[15:12] == `OPC_SECOND_WORD);
  wire dec_add   = (instr[15:10] == `OPC_ADD_W);
  wire dec_test  = (instr[15:9] == `OPC_TEST_ZERO);
  wire dec_move  = (instr[15:10] == `OPC_MOVE_FILE);
  wire dec_ret   = (instr[15:8] == `OPC_RET_LIT);

  // --------------------------------------------------------------------
  // Address forming for source and destination
  // --------------------------------------------------------------------
  reg  [11:0] src_raw;
  reg         src_banked;
  reg         src_use_bank;
  reg  [11:0] dst_raw;
  wire [11:0] src_eff;
  wire [11:0] dst_eff;

  // Bank mode comes from the command or the instruction access bit; a second transfer word is unbanked
  always @* begin
    src_raw      = {4'h0, instr[7:0]};
    src_banked   = 1'b1;
    src_use_bank = instr[8];
    dst_raw      = {4'h0, instr[7:0]};
    if (is_access) begin
      src_raw      = wb_dat_i[`ACC_ADDR_MSB:0];
      src_banked   = wb_dat_i[`ACC_BANKED_BIT];
      src_use_bank = wb_dat_i[`ACC_USEBANK_BIT];
      dst_raw      = src_raw;
    end else if (dec_word2) begin
      src_raw      = xfer_src_reg;
      src_banked   = 1'b0;
      dst_raw      = instr[11:0];
    end
  end

  addr_former u_src (
    .raw_addr (src_raw),
    .banked   (src_banked),
    .use_bank (src_use_bank),
    .bank_sel (bank_select_reg),
    .ptr_bus  (ptr_bus),
    .eff_addr (src_eff)
  );

  addr_former u_dst (
    .raw_addr (dst_raw),
    .banked   (src_banked),
    .use_bank (src_use_bank),
    .bank_sel (bank_select_reg),
    .ptr_bus  (ptr_bus),
    .eff_addr (dst_eff)
  );

  // --------------------------------------------------------------------
  // Special register read mux
  // --------------------------------------------------------------------
  reg [7:0] sfr_rd;
  integer   k;

  // Gaps in the special area and above storage answer zero
  always @* begin
    sfr_rd = 8'h00;
    if (rd_addr_reg == `SFR_PC_UPPER_LATCH) begin
      sfr_rd = {3'b000, pc_upper_latch};
    end else if (rd_addr_reg == `SFR_PC_HIGH_LATCH) begin
      sfr_rd = pc_high_latch;
    end else if (rd_addr_reg == `SFR_PC_LOW) begin
      sfr_rd = program_counter[7:0];
    end else if (rd_addr_reg == `SFR_TBL_UPPER) begin
      sfr_rd = {2'b00, table_pointer[21:16]};
    end else if (rd_addr_reg == `SFR_TBL_HIGH) begin
      sfr_rd = table_pointer[15:8];
    end else if (rd_addr_reg == `SFR_TBL_LOW) begin
      sfr_rd = table_pointer[7:0];
    end else if (rd_addr_reg == `SFR_TABLE_LATCH) begin
      sfr_rd = table_latch;
    end else if (rd_addr_reg == `SFR_WORKING) begin
      sfr_rd = working_register;
    end else if (rd_addr_reg == `SFR_BANK_SEL) begin
      sfr_rd = {4'h0, bank_select_reg};
    end
    for (k = 0; k < 3; k = k + 1) begin
      if (rd_addr_reg == `SFR_PTR_LO_BASE - k[11:0] * `SFR_PTR_STRIDE) begin
        sfr_rd = ptr_bus[k*12 +: 8];
      end else if (rd_addr_reg == `SFR_PTR_LO_BASE - k[11:0] * `SFR_PTR_STRIDE
                   + `SFR_PTR_HI_OFS) begin
        sfr_rd = {4'h0, ptr_bus[k*12+8 +: 4]};
      end
    end
  end

  // --------------------------------------------------------------------
  // Execute stage: operand value and destination write
  // --------------------------------------------------------------------
  wire [7:0] rd_val   = rd_gpr_reg ? ram_q : sfr_q_reg;
  wire [7:0] sum      = rd_val + working_register;
  wire       in_exec  = (state_reg == ST_EXEC);
  wire       rd_low   = (rd_addr_reg == `SFR_PC_LOW);
  reg        wr_en;
  reg  [7:0] wr_val;
  reg        w_dest;
  reg  [7:0] w_val;

  // Result goes to a file, the working register, or nowhere
  always @* begin
    wr_en  = 1'b0;
    wr_val = rd_val;
    w_dest = 1'b0;
    w_val  = rd_val;
    if (in_exec) begin
      case (op_reg)
        OP_BUS_WR: begin
          wr_en  = 1'b1;
          wr_val = bus_data_reg;
        end
        OP_ADD: begin
          wr_en  = to_file_reg;
          wr_val = sum;
          w_dest = ~to_file_reg;
          w_val  = sum;
        end
        OP_MOVE: begin
          wr_en  = to_file_reg;
          w_dest = ~to_file_reg;
        end
        OP_XFER: begin
          wr_en  = 1'b1;
        end
        default: begin
          wr_en  = 1'b0;
        end
      endcase
    end
  end

  wire wr_gpr = wr_en & (wr_addr_reg < GPR_TOP);
  wire wr_low = wr_en & (wr_addr_reg == `SFR_PC_LOW);
  // Any read of the low byte refreshes the latches, except the add operand fetch and the bus write command
  wire refresh = in_exec & rd_low & (op_reg != OP_ADD) & (op_reg != OP_BUS_WR);

  data_ram #(.AW(12), .DW(8)) u_ram (
    .ref_clk (ref_clk),
    .wr_en   (wr_gpr),
    .wr_addr (wr_addr_reg),
    .wr_data (wr_val),
    .rd_addr (rd_addr_reg), // Held address; bus decode changes after take
    .rd_data (ram_q)
  );

  // --------------------------------------------------------------------
  // Indirect pointers, one per entry
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ptr
      localparam [31:0] LO_FULL = `SFR_PTR_LO_BASE - g * `SFR_PTR_STRIDE;
      localparam [11:0] LO_ADDR = LO_FULL[11:0];
      reg [11:0] ptr_reg;
      // Upper nibble is the bank part of the full address
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          ptr_reg <= 12'h000;
        end else if (wr_en && wr_addr_reg == LO_ADDR) begin
          ptr_reg[7:0] <= wr_val;
        end else if (wr_en && wr_addr_reg == LO_ADDR + `SFR_PTR_HI_OFS) begin
          ptr_reg[11:8] <= wr_val[3:0];
        end
      end
      assign ptr_bus[g*12 +: 12] = ptr_reg;
    end
  endgenerate

  // --------------------------------------------------------------------
  // Control sequencer and bus answer
  // --------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg        <= ST_IDLE;
      op_reg           <= OP_BUS_RD;
      to_file_reg      <= 1'b0;
      bus_data_reg     <= 8'h00;
      wb_ack_o         <= 1'b0;
      wb_dat_o         <= 32'h00000000;
      skip_pending_reg <= 1'b0;
      xfer_pending_reg <= 1'b0;
      xfer_src_reg     <= 12'h000;
      rd_addr_reg      <= 12'h000;
      wr_addr_reg      <= 12'h000;
      sfr_q_reg        <= 8'h00;
      rd_gpr_reg       <= 1'b0;
      last_read_reg    <= 8'h00;
      return_addr_reg  <= `PC_RESET;
    end else begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      case (state_reg)
        ST_IDLE: begin
          rd_addr_reg <= src_eff;
          wr_addr_reg <= dst_eff;
          to_file_reg <= instr[9];
          if (is_access) begin
            op_reg       <= wb_dat_i[`ACC_WRITE_BIT] ? OP_BUS_WR : OP_BUS_RD;
            bus_data_reg <= wb_dat_i[`ACC_DATA_MSB:`ACC_DATA_LSB];
            state_reg    <= ST_READ;
          end else if (is_instr && skip_pending_reg) begin
            skip_pending_reg <= 1'b0;
            xfer_pending_reg <= 1'b0;
            wb_ack_o         <= 1'b1;
          end else if (is_instr && dec_word2 && xfer_pending_reg) begin
            op_reg           <= OP_XFER;
            xfer_pending_reg <= 1'b0;
            state_reg        <= ST_READ;
          end else if (is_instr && (dec_add || dec_test || dec_move)) begin
            op_reg           <= dec_add ? OP_ADD : (dec_test ? OP_TEST : OP_MOVE);
            xfer_pending_reg <= 1'b0;
            state_reg        <= ST_READ;
          end else if (is_instr) begin
            xfer_pending_reg <= dec_xfer1;
            xfer_src_reg     <= instr[11:0];
            wb_ack_o         <= 1'b1;
          end else if (take) begin
            wb_ack_o <= 1'b1;
            if (take_wr && reg_ofs == `REG_RETURN) begin
              return_addr_reg <= wb_dat_i[20:0] & ~(`PC_STEP / 2);
            end
            if (!wb_we_i) begin
              if (reg_ofs == `REG_PC) begin
                wb_dat_o <= {11'h000, program_counter};
              end else if (reg_ofs == `REG_RETURN) begin
                wb_dat_o <= {11'h000, return_addr_reg};
              end else if (reg_ofs == `REG_STATUS) begin
                wb_dat_o <= {30'h00000000, xfer_pending_reg, skip_pending_reg};
              end else if (reg_ofs == `REG_LAST_READ) begin
                wb_dat_o <= {24'h000000, last_read_reg};
              end else begin
                wb_dat_o <= 32'h00000000;
              end
            end
          end
        end
        ST_READ: begin
          sfr_q_reg  <= sfr_rd;
          rd_gpr_reg <= (rd_addr_reg < GPR_TOP);
          state_reg  <= ST_EXEC;
        end
        ST_EXEC: begin
          if (op_reg == OP_BUS_RD) begin
            last_read_reg <= rd_val;
          end
          if (op_reg == OP_TEST && rd_val == 8'h00) begin
            skip_pending_reg <= 1'b1;
          end
          wb_ack_o  <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Program counter, latches and core special registers
  // --------------------------------------------------------------------
  // The counter steps at instruction take, so a low byte read sees next address
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      program_counter  <= `PC_RESET;
      pc_high_latch    <= 8'h00;
      pc_upper_latch   <= 5'h00;
      working_register <= 8'h00;
      bank_select_reg  <= 4'h0;
      table_pointer    <= 22'h000000;
      table_latch      <= 8'h00;
    end else begin
      if (is_instr && dec_ret && !skip_pending_reg) begin
        working_register <= instr[7:0];
        program_counter  <= return_addr_reg;
      end else if (is_instr) begin
        program_counter  <= program_counter + `PC_STEP;
      end else if (take_wr && reg_ofs == `REG_PC) begin
        program_counter  <= wb_dat_i[20:0] & ~(`PC_STEP / 2);
      end else if (wr_low) begin
        program_counter  <= {pc_upper_latch, pc_high_latch, wr_val[7:1], 1'b0};
      end
      if (refresh) begin
        pc_high_latch  <= program_counter[15:8];
        pc_upper_latch <= program_counter[20:16];
      end else if (wr_en && wr_addr_reg == `SFR_PC_HIGH_LATCH) begin
        pc_high_latch  <= wr_val;
      end else if (wr_en && wr_addr_reg == `SFR_PC_UPPER_LATCH) begin
        pc_upper_latch <= wr_val[4:0];
      end
      if (w_dest) begin
        working_register <= w_val;
      end else if (wr_en && wr_addr_reg == `SFR_WORKING) begin
        working_register <= wr_val;
      end
      if (wr_en && wr_addr_reg == `SFR_BANK_SEL) begin
        bank_select_reg <= wr_val[3:0];
      end
      // Table pointer and latch move one byte per access
      if (wr_en && wr_addr_reg == `SFR_TBL_UPPER) begin
        table_pointer[21:16] <= wr_val[5:0];
      end else if (wr_en && wr_addr_reg == `SFR_TBL_HIGH) begin
        table_pointer[15:8] <= wr_val;
      end else if (wr_en && wr_addr_reg == `SFR_TBL_LOW) begin
        table_pointer[7:0] <= wr_val;
      end
      if (wr_en && wr_addr_reg == `SFR_TABLE_LATCH) begin
        table_latch <= wr_val;
      end
    end
  end

endmodule // banked_data_memory_addressing

// ===== verif/core_pipeline_model.sv
// ----------------------------------------------------------------------
// Execution pipeline stand-in on the classic Wishbone port
// ----------------------------------------------------------------------
module core_pipeline_model (
  input  wire         ref_clk,
  input  wire         wb_ack_o,
  output logic        wb_cyc_i,
  output logic        wb_stb_i,
  output logic        wb_we_i,
  output logic [7:0]  wb_adr_i,
  output logic [3:0]  wb_sel_i,
  output logic [31:0] wb_dat_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus from time zero
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'hff;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
  end

  // One request, held until ack is sampled, then released for a cycle
  task automatic bus_cycle(input logic we, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // Released lines show no stale value
    wb_adr_i <= ~a;
    wb_dat_i <= ~d;
  endtask
endmodule // core_pipeline_model

// ===== verif/banked_mem_checker_sva.sv
`include "banked_mem_defs.vh"
// ----------------------------------------------------------------------
// Port checks of the banked memory block
// ----------------------------------------------------------------------
module banked_mem_checker #(
  parameter GPR_TOP = `GPR_LIMIT
) (
  input wire        ref_clk,
  input wire        sys_rst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire [20:0] program_counter
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // First cycle of a request; the master idles between requests
  sequence req_start;
    wb_cyc_i && wb_stb_i && !$past(wb_stb_i);
  endsequence
  sequence access_cmd;
    wb_we_i && wb_sel_i[0] && wb_adr_i == `REG_ACCESS;
  endsequence
  sequence lone_word;
    wb_we_i && wb_sel_i[0] && wb_adr_i == `REG_INSTR && wb_dat_i[15:12] == `OPC_SECOND_WORD;
  endsequence

  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_bounded_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:3] wb_ack_o)
    else $error("request not answered in time");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data nonzero outside ack");
  a_access_three_cycles: assert property (req_start ##0 access_cmd |=> !wb_ack_o [*2] ##1 wb_ack_o)
    else $error("memory command answer not at third cycle");
  a_read_one_cycle: assert property (req_start ##0 !wb_we_i |=> wb_ack_o)
    else $error("read answer late");
  a_unmapped_reads_zero: assert property (req_start ##0 (!wb_we_i && wb_adr_i >= 8'h18)
    |=> wb_dat_o == 32'h0) else $error("unmapped read nonzero");
  a_pc_read_match: assert property (req_start ##0 (!wb_we_i && wb_adr_i == `REG_PC)
    |=> wb_dat_o == {11'h0, program_counter}) else $error("counter read mismatch");
  a_pc_always_even: assert property (program_counter[0] == 1'b0)
    else $error("counter odd");
  a_pc_idle_stable: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(program_counter))
    else $error("counter moved without request");
  a_lone_word_step: assert property (req_start ##0 lone_word
    |=> program_counter == $past(program_counter) + `PC_STEP) else $error("second word step");
  a_reset_clears_pc: assert property ($fell(sys_rst) |-> program_counter == `PC_RESET && !wb_ack_o)
    else $error("counter not cleared by reset");
endmodule // banked_mem_checker

// ===== verif/test_banked_data_memory_addressing.sv
`include "banked_mem_defs.vh"
module test_banked_data_memory_addressing;
  timeunit 1ns;
  timeprecision 1ps;
  localparam GPR_TOP = `GPR_LIMIT;
  logic        ref_clk;
  logic        sys_rst;
  wire         wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  wire  [7:0]  wb_adr_i;
  wire  [3:0]  wb_sel_i;
  wire  [31:0] wb_dat_i, wb_dat_o;
  wire  [20:0] program_counter;
  logic [31:0] exp_q[$];
  logic [31:0] e;
  logic [11:0] ta;
  logic [7:0]  v1, v2, v3, v4, r, k;
  logic [7:0]  offs[3] = '{8'h18, 8'h88, 8'hfc};
  int          error_cnt, n_tests, cyc_cnt;
  integer      seed;

  banked_data_memory_addressing #(.GPR_TOP(GPR_TOP)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .program_counter(program_counter));
  core_pipeline_model host (
    .ref_clk(ref_clk), .wb_ack_o(wb_ack_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i));

  // ----------------------------------------------------------------------
  // Bus helpers: expected read data is noted before the request goes out
  // ----------------------------------------------------------------------
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    host.bus_cycle(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic acc_wr(input logic [11:0] a, input logic [7:0] d);
    host.bus_cycle(1'b1, `REG_ACCESS, {8'h0, d, 4'h4, a}, 4'hf);
  endtask
  task automatic acc_rd(input logic [11:0] a, input logic [7:0] x);
    host.bus_cycle(1'b1, `REG_ACCESS, {20'h0, a}, 4'hf);
    chk_rd(`REG_LAST_READ, {24'h0, x});
  endtask
  task automatic bnk_wr(input logic [7:0] f, input logic u, input logic [7:0] d);
    host.bus_cycle(1'b1, `REG_ACCESS, {8'h0, d, 2'b01, u, 1'b1, 4'h0, f}, 4'hf);
  endtask
  task automatic instr(input logic [15:0] w);
    host.bus_cycle(1'b1, `REG_INSTR, {16'h0, w}, 4'hf);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Each read answer is matched with the oldest note
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      n_tests++;
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("[FAIL] %0t unexpected read answer", $time);
      end else begin
        e = exp_q.pop_front();
        if (wb_dat_o !== e) begin
          error_cnt++;
          $display("[FAIL] %0t read %h expected %h", $time, wb_dat_o, e);
        end
      end
    end
  end

  // Hang guard, far above the few hundred clock cycles needed
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 8000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      stop_test();
    end
  end

  // Main sequence
  initial begin
    seed = 32'hfea6;
    sys_rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk_rd(`REG_PC, 32'h0);
    chk_rd(`REG_STATUS, 32'h0);
    chk_rd(`REG_RETURN, 32'h0);
    for (int i = 0; i < 3; i++) begin
      host.bus_cycle(1'b1, offs[i], $random(seed), 4'hf);
      chk_rd(offs[i], 32'h0);
    end
    host.bus_cycle(1'b1, `REG_PC, 32'h100, 4'he);
    chk_rd(`REG_PC, 32'h0);
    v1 = $random(seed);
    v2 = $random(seed);
    v3 = $random(seed);
    v4 = $random(seed);
    acc_wr(`SFR_BANK_SEL, 8'hf3);
    acc_rd(`SFR_BANK_SEL, 8'h03);
    bnk_wr(8'h45, 1'b1, v1);
    acc_rd(12'h345, v1);
    bnk_wr(8'h45, 1'b0, v2);
    acc_rd(12'h045, v2);
    bnk_wr(8'he8, 1'b0, v3);
    acc_rd(`SFR_WORKING, v3);
    acc_wr(12'hebc, ~v2);
    acc_rd(12'hebc, ~v2);
    acc_wr(12'hf5f, v3);
    acc_rd(12'hf5f, v3);
    acc_wr(12'hf60, 8'haa);
    acc_rd(12'hf60, 8'h00);
    acc_rd(12'hfd4, 8'h00);
    acc_wr(12'hfe9, 8'h45);
    acc_wr(12'hfea, 8'h03);
    acc_rd(12'hfef, v1);
    acc_wr(12'hfef, v4);
    acc_rd(12'h345, v4);
    // Test on nonzero, then on zero so the transfer is skipped
    acc_wr(12'h010, 8'h01);
    acc_wr(12'h124, 8'h77);
    host.bus_cycle(1'b1, `REG_PC, 32'h0, 4'hf);
    instr(16'h6610);
    instr(16'hc345);
    chk_rd(`REG_STATUS, 32'h2);
    instr(16'hf123);
    acc_rd(12'h123, v4);
    acc_wr(12'h010, 8'h00);
    instr(16'h6610);
    chk_rd(`REG_STATUS, 32'h1);
    instr(16'hc345);
    instr(16'hf124);
    acc_rd(12'h124, 8'h77);
    chk_rd(`REG_PC, 32'hc);
    // Computed jump through the counter low byte
    host.bus_cycle(1'b1, `REG_PC, 32'h0a12c1, 4'hf);
    chk_rd(`REG_PC, 32'h0a12c0);
    instr(16'h50f9);
    acc_rd(`SFR_PC_UPPER_LATCH, 8'h0a);
    acc_rd(`SFR_PC_HIGH_LATCH, 8'h12);
    acc_rd(`SFR_WORKING, 8'hc2);
    r = $random(seed);
    acc_wr(`SFR_PC_UPPER_LATCH, 8'h05);
    acc_wr(`SFR_PC_HIGH_LATCH, 8'h66);
    acc_wr(`SFR_WORKING, r);
    instr(16'h26f9);
    chk_rd(`REG_PC, {11'h0, 5'h05, 8'h66, (8'hc4 + r) & 8'hfe});
    acc_rd(`SFR_PC_UPPER_LATCH, 8'h05);
    acc_rd(`SFR_PC_HIGH_LATCH, 8'h66);
    acc_wr(`SFR_PC_LOW, 8'h39);
    chk_rd(`REG_PC, 32'h056638);
    k = $random(seed);
    host.bus_cycle(1'b1, `REG_RETURN, 32'h1231, 4'hf);
    chk_rd(`REG_RETURN, 32'h1230);
    instr({`OPC_RET_LIT, k});
    chk_rd(`REG_PC, 32'h1230);
    acc_rd(`SFR_WORKING, k);
    for (ta = `SFR_TABLE_LATCH; ta <= `SFR_TBL_HIGH; ta++) begin
      r = $random(seed);
      acc_wr(ta, r);
      acc_rd(ta, r);
    end
    // Storage survives a reset in mid-run
    acc_wr(12'h200, v2);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    acc_rd(12'h200, v2);
    chk_rd(`REG_PC, 32'h0);
    @(posedge ref_clk);
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("[FAIL] %0t reads left unanswered", $time);
    end
    stop_test();
  end
endmodule // test_banked_data_memory_addressing

bind banked_data_memory_addressing banked_mem_checker #(.GPR_TOP(GPR_TOP)) chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .program_counter(program_counter));
